/* rtl/wdsc_top.sv */
// Watchdog counter with reset request, reset-cause flag and latch strobe inhibit.
// Assumes an 8-bit register port and that dog_reset_req is fed back as a device reset.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Contract
// RQ1 - Sixteen-bit counter overflow requests device reset
// RQ2 - Run enable bit seven starts counting
// RQ3 - Any reset clears the run enable
// RQ4 - Software restarts before the timeout expires
// RQ5 - Restart bit five zeroes the counter
// RQ6 - Divider field picks eight to 1024
// RQ7 - Overflow reset sets the cause flag
// RQ8 - Software reads cause flag after reset
// RQ9 - Inhibit bit zero suppresses latch strobe
// RQ10 - Restart bit pulses, reads back zero
// RQ11 - Cause flag survives its reset, software clears
module wdsc_top #(
    parameter int CNT_W = wdsc_pkg::DOG_W
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         ext_reset_n,
    input  wire logic [wdsc_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [wdsc_pkg::REG_DW-1:0]  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [wdsc_pkg::REG_DW-1:0]  reg_rdata,
    output logic                              dog_reset_req,
    output logic                              latch_strobe,
    output logic                              irq
);
    import wdsc_pkg::*;

    logic                 dog_run_enable_r;
    logic [DIV_W-1:0]     timebase_divider_select_r;
    logic                 latch_strobe_inhibit_r;
    logic                 dog_reset_cause_flag_r;
    logic [CNT_W-1:0]     watchdog_counter_r;
    logic                 dog_reset_req_r;
    logic [IRQ_W-1:0]     irq_status_r;
    logic [IRQ_W-1:0]     irq_enable_r;
    logic                 tick;
    logic                 overflow;
    logic                 dog_counter_restart;
    logic                 wr_dog;
    logic                 wr_sys;
    logic                 wr_ien;
    logic                 wr_iclr;
    logic                 any_reset_n;
    logic [IRQ_W-1:0]     irq_events;
    logic [REG_DW-1:0]    rdata_nxt;

    // Address match shared by all write decodes
    function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] target);
        return a == target;
    endfunction

    assign wr_dog  = reg_wr && hit(reg_addr, ADDR_DOG_CTRL);
    assign wr_sys  = reg_wr && hit(reg_addr, ADDR_SYS_CTRL);
    assign wr_ien  = reg_wr && hit(reg_addr, ADDR_IRQ_ENABLE);
    assign wr_iclr = reg_wr && hit(reg_addr, ADDR_IRQ_CLEAR);

    // Restart exists only as the write cycle itself, never stored
    assign dog_counter_restart = wr_dog && reg_wdata[BIT_RESTART]; // RQ10

    // Device reset seen by this block: bus reset, external pin, or our own request
    assign any_reset_n = rst_n && ext_reset_n && !dog_reset_req_r;

    // Control bits; a watchdog reset clears them just like the pin does
    always_ff @(posedge mclk) begin
        if (!any_reset_n) begin
            dog_run_enable_r          <= 1'b0; // RQ3
            timebase_divider_select_r <= DIV_RESET;
        end else if (wr_dog) begin
            dog_run_enable_r          <= reg_wdata[BIT_RUN_ENABLE]; // RQ2
            timebase_divider_select_r <= reg_wdata[DIV_LSB +: DIV_W]; // RQ6
        end
    end

    // Inhibit bit follows the device reset too
    always_ff @(posedge mclk) begin
        if (!any_reset_n) begin
            latch_strobe_inhibit_r <= 1'b0;
        end else if (wr_sys) begin
            latch_strobe_inhibit_r <= reg_wdata[BIT_STROBE_INHIB]; // RQ9
        end
    end

    wdsc_prescaler #(
        .W       (PRESCALE_W)
    ) u_pre (
        .mclk    (mclk),
        .rst_n   (any_reset_n),
        .run     (dog_run_enable_r),
        .restart (dog_counter_restart),
        .sel     (timebase_divider_select_r),
        .tick    (tick)
    );

    assign overflow = tick && (watchdog_counter_r == {CNT_W{1'b1}}); // RQ1

    // Counter; restart wins over a tick in the same cycle
    always_ff @(posedge mclk) begin
        if (!any_reset_n || dog_counter_restart) begin
            watchdog_counter_r <= '0; // RQ5
        end else if (tick) begin
            watchdog_counter_r <= CNT_W'(watchdog_counter_r + CNT_W'(1)); // RQ1
        end
    end

    // One-cycle reset request; held off by the pin so it cannot latch up
    always_ff @(posedge mclk) begin
        if (!rst_n || !ext_reset_n) begin
            dog_reset_req_r <= 1'b0;
        end else begin
            dog_reset_req_r <= overflow && dog_run_enable_r; // RQ1
        end
    end
    assign dog_reset_req = dog_reset_req_r;

    // Cause flag only sees bus reset; the watchdog reset must not wipe it.
    // Set wins over a software clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dog_reset_cause_flag_r <= 1'b0;
        end else if (dog_reset_req_r) begin
            dog_reset_cause_flag_r <= 1'b1; // RQ7 RQ11
        end else if (wr_sys && !reg_wdata[BIT_CAUSE_FLAG]) begin
            dog_reset_cause_flag_r <= 1'b0; // RQ11
        end
    end

    wdsc_strobe_gen #(
        .DIV     (STROBE_DIV)
    ) u_strobe (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .inhibit (latch_strobe_inhibit_r),
        .strobe  (latch_strobe)
    );

    // Sticky events: restart seen and overflow reset issued; set beats clear
    assign irq_events = {dog_reset_req_r, dog_counter_restart};
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= irq_events | (irq_status_r & ~(wr_iclr ? reg_wdata[IRQ_W-1:0] : '0));
        end
    end

    // Enable mask survives the watchdog reset so the event is not hidden
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_enable_r <= '0;
        end else if (wr_ien) begin
            irq_enable_r <= reg_wdata[IRQ_W-1:0];
        end
    end
    assign irq = |(irq_status_r & irq_enable_r);

    // Read mux; restart bit and unused bits read zero, unmapped reads zero
    always_comb begin
        rdata_nxt = DATA_ZERO;
        unique case (reg_addr)
            ADDR_DOG_CTRL: begin
                rdata_nxt[BIT_RUN_ENABLE]      = dog_run_enable_r;
                rdata_nxt[DIV_LSB +: DIV_W]    = timebase_divider_select_r; // RQ10
            end
            ADDR_SYS_CTRL: begin
                rdata_nxt[BIT_CAUSE_FLAG]      = dog_reset_cause_flag_r;
                rdata_nxt[BIT_STROBE_INHIB]    = latch_strobe_inhibit_r;
            end
            ADDR_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_status_r;
            ADDR_IRQ_ENABLE: rdata_nxt[IRQ_W-1:0] = irq_enable_r;
            default:         rdata_nxt = DATA_ZERO;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= DATA_ZERO;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Overflow while running yields a reset request next cycle
    chk_overflow_to_reset: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        (overflow && dog_run_enable_r && ext_reset_n) |=> dog_reset_req)
        else $error("overflow did not request reset");

    // Writing enable gives run enable next cycle
    chk_enable_write: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        (wr_dog && reg_wdata[BIT_RUN_ENABLE] && any_reset_n) |=> dog_run_enable_r)
        else $error("run enable not set by write");

    // Reset request clears run enable
    chk_reset_clears_run: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
        dog_reset_req |=> !dog_run_enable_r)
        else $error("run enable survived watchdog reset");

    // Restart zeroes the counter
    chk_restart_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        dog_counter_restart |=> (watchdog_counter_r == '0))
        else $error("restart did not zero counter");

    // Counter only moves on a tick
    chk_count_on_tick: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        (!tick && !dog_counter_restart && any_reset_n) |=> $stable(watchdog_counter_r))
        else $error("counter moved without tick");

    // Cause flag set after the request
    chk_cause_set: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        dog_reset_req |=> dog_reset_cause_flag_r)
        else $error("cause flag not set");

    // Cause flag holds unless software writes zero
    chk_cause_sticky: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
        (dog_reset_cause_flag_r && !(wr_sys && !reg_wdata[BIT_CAUSE_FLAG])) |=> dog_reset_cause_flag_r)
        else $error("cause flag lost");

    // Inhibited strobe stays low
    chk_strobe_inhibit: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        (latch_strobe_inhibit_r && $past(latch_strobe_inhibit_r)) |-> !latch_strobe)
        else $error("strobe while inhibited");

    // Restart bit reads back as zero
    chk_restart_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
        (reg_rd && hit(reg_addr, ADDR_DOG_CTRL)) |=> !reg_rdata[BIT_RESTART])
        else $error("restart bit read as one");

    // Overflow chain steps: the overflow, the one-cycle request, then the cleared aftermath
    sequence s_dog_overflow;
        overflow && dog_run_enable_r && ext_reset_n;
    endsequence
    sequence s_dog_request;
        dog_reset_req;
    endsequence
    sequence s_dog_aftermath;
        !dog_reset_req && !dog_run_enable_r && (watchdog_counter_r == '0) && dog_reset_cause_flag_r;
    endsequence

    // Whole overflow sequence ends with a stopped, zeroed counter and the cause recorded
    chk_overflow_chain: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        s_dog_overflow |=> s_dog_request ##1 s_dog_aftermath)
        else $error("overflow chain broken");

    // Reset request lasts exactly one cycle
    chk_req_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        dog_reset_req |=> !dog_reset_req)
        else $error("reset request longer than one cycle");

    // No reset request without an enabled overflow
    chk_req_needs_overflow: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        dog_reset_req |-> $past(overflow && dog_run_enable_r))
        else $error("reset request without overflow");

    // Counter steps by one on every accepted tick
    chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        (tick && any_reset_n && !dog_counter_restart) |=>
            (watchdog_counter_r == CNT_W'($past(watchdog_counter_r) + 1'b1)))
        else $error("counter did not step on tick");

    // Run enable holds until written or reset
    chk_run_holds: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        (dog_run_enable_r && any_reset_n && !wr_dog) |=> dog_run_enable_r)
        else $error("run enable dropped on its own");

    // Run enable reads back as stored
    chk_read_run: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        (reg_rd && hit(reg_addr, ADDR_DOG_CTRL)) |=> (reg_rdata[BIT_RUN_ENABLE] == $past(dog_run_enable_r)))
        else $error("run enable read back wrong");

    // External reset pin clears control, counter and inhibit
    chk_ext_clears: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
        !ext_reset_n |=> (!dog_run_enable_r && (watchdog_counter_r == '0) && !latch_strobe_inhibit_r))
        else $error("external reset left state behind");

    // Restart also restarts the divider phase, so no tick follows at once
    chk_restart_phase: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        dog_counter_restart |=> !tick)
        else $error("tick right after restart");

    // Ticks are at least eight clocks apart
    chk_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        tick |=> !tick [*7])
        else $error("ticks closer than eight clocks");

    // Divider field takes the written code
    chk_divider_write: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        (wr_dog && any_reset_n) |=> (timebase_divider_select_r == $past(reg_wdata[DIV_LSB +: DIV_W])))
        else $error("divider code not stored");

    // Inhibit bit takes the written value
    chk_inhibit_write: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        (wr_sys && any_reset_n) |=> (latch_strobe_inhibit_r == $past(reg_wdata[BIT_STROBE_INHIB])))
        else $error("inhibit bit not stored");

    // Strobe pulses stay six clocks apart
    chk_strobe_spacing: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        latch_strobe |=> !latch_strobe [*5])
        else $error("strobe pulses too close");

    // Only a watchdog request can set the cause flag
    chk_cause_not_by_ext: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
        (!dog_reset_cause_flag_r && !dog_reset_req) |=> !dog_reset_cause_flag_r)
        else $error("cause flag set without watchdog reset");
endmodule

/* rtl/wdsc_pkg.sv */
// Package for the watchdog and system control block: offsets, fields, reset values, timing.
// Assumes an 8-bit register port at the printed special-register addresses.
package wdsc_pkg;
    localparam int          REG_AW            = 8;
    localparam int          REG_DW            = 8;
    localparam logic [7:0]  ADDR_DOG_CTRL     = 8'h9f;
    localparam logic [7:0]  ADDR_SYS_CTRL     = 8'hbf;
    localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'hc0;
    localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'hc1;
    localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'hc2;
    localparam int          BIT_RUN_ENABLE    = 7;
    localparam int          BIT_RESTART       = 5;
    localparam int          DIV_LSB           = 0;
    localparam int          DIV_W             = 3;
    localparam int          BIT_CAUSE_FLAG    = 7;
    localparam int          BIT_STROBE_INHIB  = 0;
    localparam int          IRQ_W             = 2;
    localparam int          IRQ_BIT_RESTART   = 0;
    localparam int          IRQ_BIT_OVERFLOW  = 1;
    localparam int          DOG_W             = 16;
    localparam int          PRESCALE_BASE_LOG = 3;
    localparam int          PRESCALE_W        = 10;
    localparam int          STROBE_DIV        = 6;
    localparam logic [7:0]  DATA_ZERO         = 8'h00;
    localparam logic [2:0]  DIV_RESET         = 3'h0;
    localparam int          CLK_PERIOD_NS     = 20;
endpackage

/* rtl/wdsc_prescaler.sv */
// Oscillator divider for the counter time base: one tick every 8 to 1024 clocks.
// Assumes a free-running mclk; restart clears the phase so timeouts start full.
`timescale 1ns/1ps
module wdsc_prescaler #(
    parameter int W = wdsc_pkg::PRESCALE_W
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      run,
    input  wire logic                      restart,
    input  wire logic [wdsc_pkg::DIV_W-1:0] sel,
    output logic                           tick
);
    import wdsc_pkg::*;
    logic [W-1:0] pre_r;
    logic [W-1:0] limit;

    // Terminal count is 2^(sel+3)-1; the shift amount is one bit wider than sel so codes 5 to 7 do not wrap
    assign limit = W'((W'(1) << ((DIV_W + 1)'(sel) + (DIV_W + 1)'(PRESCALE_BASE_LOG))) - W'(1));
    // Compare is at-or-above, so lowering the divider mid-count cannot stretch one period to a full wrap
    assign tick  = run && (pre_r >= limit); // RQ6

    // Phase counter clears to zero when disabled so no stale tick survives
    always_ff @(posedge mclk) begin
        if (!rst_n || !run || restart || tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= W'(pre_r + W'(1)); // RQ6
        end
    end
endmodule

/* rtl/wdsc_strobe_gen.sv */
// Free-running latch strobe: one clock high out of every six, unless inhibited.
// Assumes mclk is the oscillator clock.
`timescale 1ns/1ps
module wdsc_strobe_gen #(
    parameter int DIV = wdsc_pkg::STROBE_DIV
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic inhibit,
    output logic      strobe
);
    import wdsc_pkg::*;
    logic [2:0] ph_r;

    // Phase keeps running while inhibited, so reenabling keeps the cadence
    always_ff @(posedge mclk) begin
        if (!rst_n || ph_r == 3'(DIV - 1)) begin
            ph_r <= '0;
        end else begin
            ph_r <= ph_r + 3'h1;
        end
    end

    // Registered output avoids glitches on the pin
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe <= 1'b0;
        end else begin
            strobe <= (ph_r == 3'(DIV - 1)) && !inhibit; // RQ9
        end
    end
endmodule

/* verification/wdsc_top_tb_top.sv */
// Self-checking bench for the watchdog and system control block: register table, strobe, irq, overflow.
// Assumes the plain register port: read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module wdsc_top_tb_top;
    import wdsc_pkg::*;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } wdsc_row_type;
    localparam int CW = 4; // Short counter keeps the slowest timeout near 16k clocks
    logic       mclk        = 1'b0;
    logic       rst_n       = 1'b0;
    logic       ext_reset_n = 1'b1;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic [7:0] reg_rdata;
    logic       dog_reset_req;
    logic       latch_strobe;
    logic       irq;
    int         errors      = 0;
    int         checks      = 0;
    logic [7:0] v;
    int         n;
    int         c;
    wdsc_row_type rows [6] = '{'{8'h9f, 8'h25, 8'h05}, '{8'h9f, 8'h02, 8'h02}, '{8'hbf, 8'h81, 8'h01},
                               '{8'hbf, 8'h00, 8'h00}, '{8'hc1, 8'h02, 8'h02}, '{8'h10, 8'hff, 8'h00}};

    wdsc_top #(.CNT_W(CW)) dut (.mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dog_reset_req(dog_reset_req), .latch_strobe(latch_strobe), .irq(irq));

    // Free-running oscillator clock
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    // One-cycle write; the trailing edge drops the strobe so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; data is taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Bounded wait for the reset request, counting clocks
    task automatic wait_req(output int k);
        k = 0;
        while (dog_reset_req !== 1'b1 && k < 20000) begin
            @(posedge mclk); #1; k++;
        end
    endtask

    // Counts strobe highs over sixty clocks, skipping the cycle already launched
    task automatic count_strobe(output int k);
        k = 0;
        @(posedge mclk);
        repeat (60) begin
            @(posedge mclk); #1; k += (latch_strobe === 1'b1);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard: sixty thousand clocks, about twice the summed timeouts of all scenarios
    initial begin
        #(60000 * CLK_PERIOD_NS);
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        `CHK("req_after_reset", 1'b0, dog_reset_req)
        rd(ADDR_DOG_CTRL, v); `CHK("ctrl_reset", 8'h00, v)
        rd(ADDR_SYS_CTRL, v); `CHK("sys_reset", 8'h00, v)
        // Ordinary register rows: write, then read back
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v); `CHK("row_readback", rows[i].e, v)
        end
        // Latch strobe: one in six, then fully inhibited
        count_strobe(c); `CHK("strobe_on", 10, c)
        wr(ADDR_SYS_CTRL, 8'h01);
        count_strobe(c); `CHK("strobe_off", 0, c)
        wr(ADDR_SYS_CTRL, 8'h00);
        // Restart event interrupt: raise, mask, unmask, clear
        wr(ADDR_IRQ_CLEAR, 8'h03); wr(ADDR_IRQ_ENABLE, 8'h01); wr(ADDR_DOG_CTRL, 8'h20);
        `CHK("irq_raised", 1'b1, irq)
        wr(ADDR_IRQ_ENABLE, 8'h00); `CHK("irq_masked", 1'b0, irq)
        wr(ADDR_IRQ_ENABLE, 8'h01); `CHK("irq_unmasked", 1'b1, irq)
        wr(ADDR_IRQ_CLEAR, 8'h01); `CHK("irq_cleared", 1'b0, irq)
        // Every divider code: timeout is 2^CW ticks of 8 << code clocks
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_DOG_CTRL, 8'h80 | 8'(s));
            wait_req(n);
            `CHK("timeout_len", 1'b1, (n >= (16 << s) * 8 - 4 && n <= (16 << s) * 8 + 4))
            @(posedge mclk); #1; `CHK("req_one_cycle", 1'b0, dog_reset_req)
            rd(ADDR_SYS_CTRL, v); `CHK("cause_set", 8'h80, v)
            rd(ADDR_DOG_CTRL, v); `CHK("run_cleared", 8'h00, v)
        end
        rd(ADDR_IRQ_STATUS, v); `CHK("status_ovf", 1'b1, v[IRQ_BIT_OVERFLOW])
        // Late restart must push the overflow a full timeout out
        wr(ADDR_DOG_CTRL, 8'h80);
        repeat (100) @(posedge mclk);
        wr(ADDR_DOG_CTRL, 8'ha0);
        wait_req(n); `CHK("restart_len", 1'b1, (n >= 124 && n <= 140))
        // External reset clears control and inhibit but keeps the cause flag
        wr(ADDR_SYS_CTRL, 8'h81); wr(ADDR_DOG_CTRL, 8'h83);
        @(posedge mclk); ext_reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        ext_reset_n <= 1'b1;
        rd(ADDR_DOG_CTRL, v); `CHK("ext_ctrl", 8'h00, v)
        rd(ADDR_SYS_CTRL, v); `CHK("ext_keeps_flag", 8'h80, v)
        wr(ADDR_SYS_CTRL, 8'h00);
        rd(ADDR_SYS_CTRL, v); `CHK("flag_cleared", 8'h00, v)
        tally_and_finish();
    end
endmodule
